// File: logic/serial_flash_defines.vh
`ifndef SERIAL_FLASH_DEFINES_VH
`define SERIAL_FLASH_DEFINES_VH

`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_STATUS_LOW 8'h05
`define CMD_READ_STATUS_HIGH 8'h35
`define CMD_READ_CONFIG 8'h15
`define CMD_WRITE_STATUS_LOW 8'h01
`define CMD_WRITE_STATUS_HIGH 8'h31
`define CMD_WRITE_CONFIG 8'h11

`define BITS_CMD 5'h08
`define BITS_ONE_BYTE 5'h10
`define BITS_TWO_BYTES 5'h18

`define STATUS_WRITE_MASK 16'h7bfc
`define STATUS_RESET 16'h0000
`define STAT_COMPLEMENT 14
`define STAT_QUAD_ENABLE 9
`define STAT_MODE_HIGH 8
`define STAT_MODE_LOW 7

`define CFG_HOLD_RESET 7
`define CFG_DRIVE_HI 6
`define CFG_DRIVE_LO 5
`define CFG_PAGE_HI 4
`define CFG_PAGE_LO 3
`define CFG_PROT_SCHEME 2
`define CFG_DUMMY_SEL 1
`define CFG_TRAINING 0
`define CONFIG_RESET 8'h00

`define PAGE_256 2'b00
`define PAGE_512 2'b01
`define PAGE_1024 2'b10
`define WRAP_256 10'h0ff
`define WRAP_512 10'h1ff
`define WRAP_1024 10'h3ff
`define DUMMY_SHORT 4'h4
`define DUMMY_LONG 4'h8
`define TRAINING_PATTERN 8'h34
`define BLOCK_LOCK_RESET 1'b1

`define CLK_PERIOD_NS 5
`define REG_WRITE_TIME_NS 10000
`define REG_WRITE_CYCLES \
    ((`REG_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: logic/flash_pin_sync.v
`default_nettype none
// three stages; a change counts once stages two and three agree
module flash_pin_sync #(
    parameter [0:0] RESET_VALUE = 1'b0
) (
    input wire sys_clk,
    input wire reset_n,
    input wire pin,
    output reg level
);
    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            level <= RESET_VALUE;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/flash_config_status_regs.v
`include "serial_flash_defines.vh"
`default_nettype none
module flash_config_status_regs #(
    parameter WRITE_CYCLES = `REG_WRITE_CYCLES
) (
    input wire sys_clk,
    input wire reset_n,
    input wire cs_n,
    input wire sclk,
    input wire si,
    input wire wp_n,
    output reg so,
    output reg so_oe,
    output reg write_busy_flag,
    output reg write_enable_latch,
    output reg hold_reset_select,
    output reg [1:0] drive_strength,
    output reg [1:0] page_size,
    output reg [9:0] page_wrap_mask,
    output reg [2:0] erase_page_span,
    output reg protection_scheme_select,
    output reg block_locks_set,
    output reg [3:0] dummy_clocks,
    output reg training_pattern_enable,
    output reg [7:0] training_pattern
);
    localparam [1:0] ST_READY = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;
    localparam [31:0] WRITE_LAST = WRITE_CYCLES - 1;

    wire cs_s;
    wire sclk_s;
    wire si_s;
    wire wp_s;

    reg sclk_d;
    reg cs_d;
    reg [4:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] cmd;
    reg [7:0] data0;
    reg [7:0] data1;
    reg [7:0] out_byte;
    reg [1:0] state;
    reg [31:0] cycle_cnt;
    reg [15:0] status_bits;
    reg [15:0] pend_status;
    reg [7:0] pend_cfg;

    flash_pin_sync #(.RESET_VALUE(1'b1)) sync_cs (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(cs_n),
        .level(cs_s)
    );

    flash_pin_sync #(.RESET_VALUE(1'b0)) sync_sclk (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(sclk),
        .level(sclk_s)
    );

    flash_pin_sync #(.RESET_VALUE(1'b0)) sync_si (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(si),
        .level(si_s)
    );

    flash_pin_sync #(.RESET_VALUE(1'b1)) sync_wp (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(wp_n),
        .level(wp_s)
    );

    // si and sclk share the same sync depth, so they stay aligned
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire cs_rise = cs_s & ~cs_d;
    wire [7:0] shift_in = {shreg[6:0], si_s};
    wire ready = (state == ST_READY);

    // reads show committed values only, never the pending ones
    wire [7:0] config_now = {hold_reset_select, drive_strength,
        page_size, protection_scheme_select, dummy_clocks[3],
        training_pattern_enable};
    wire [15:0] status_now = {status_bits[15:2], write_enable_latch,
        write_busy_flag};

    wire is_read = (cmd == `CMD_READ_STATUS_LOW) ||
        (cmd == `CMD_READ_STATUS_HIGH) || (cmd == `CMD_READ_CONFIG);

    // protection modes 10 and 11 lock as well
    wire [1:0] prot_mode = {status_bits[`STAT_MODE_HIGH],
        status_bits[`STAT_MODE_LOW]};
    wire hw_locked = (prot_mode == 2'b01 && !wp_s) | prot_mode[1];
    wire write_ok = write_enable_latch & ready & ~hw_locked;

    wire [15:0] low_merge = (status_bits & ~(`STATUS_WRITE_MASK &
        16'h00ff)) | ({8'h00, data0} & `STATUS_WRITE_MASK);
    wire [15:0] high_from0 = (status_bits & ~(`STATUS_WRITE_MASK &
        16'hff00)) | ({data0, 8'h00} & `STATUS_WRITE_MASK);
    wire [15:0] both_merge = (low_merge & ~(`STATUS_WRITE_MASK &
        16'hff00)) | ({data1, 8'h00} & `STATUS_WRITE_MASK);
    reg [15:0] low_only;

    always @* begin
        low_only = low_merge;
        low_only[`STAT_COMPLEMENT] = 1'b0;
        low_only[`STAT_QUAD_ENABLE] = 1'b0;
        low_only[`STAT_MODE_HIGH] = 1'b0;
    end

    reg [7:0] read_value;

    always @* begin
        if (shift_in == `CMD_READ_STATUS_LOW) begin
            read_value = status_now[7:0];
        end else if (shift_in == `CMD_READ_STATUS_HIGH) begin
            read_value = status_now[15:8];
        end else if (shift_in == `CMD_READ_CONFIG) begin
            read_value = config_now;
        end else begin
            read_value = 8'h00;
        end
    end

    // derived controls of the pending configuration
    wire [1:0] next_page = pend_cfg[`CFG_PAGE_HI:`CFG_PAGE_LO];
    reg [9:0] next_wrap;
    reg [2:0] next_span;

    always @* begin
        if (next_page == `PAGE_512) begin
            next_wrap = `WRAP_512;
            next_span = 3'h2;
        end else if (next_page == `PAGE_1024) begin
            next_wrap = `WRAP_1024;
            next_span = 3'h4;
        end else begin
            // reserved code falls back to the legacy 256-byte wrap
            next_wrap = `WRAP_256;
            next_span = 3'h1;
        end
    end

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            bit_cnt <= 5'h00;
            shreg <= 8'h00;
            cmd <= 8'h00;
            data0 <= 8'h00;
            data1 <= 8'h00;
            out_byte <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
            state <= ST_READY;
            cycle_cnt <= 32'h0;
            write_busy_flag <= 1'b0;
            write_enable_latch <= 1'b0;
            status_bits <= `STATUS_RESET;
            pend_status <= `STATUS_RESET;
            pend_cfg <= `CONFIG_RESET;
            hold_reset_select <= 1'b0;
            drive_strength <= 2'b00;
            page_size <= `PAGE_256;
            page_wrap_mask <= `WRAP_256;
            erase_page_span <= 3'h1;
            protection_scheme_select <= 1'b0;
            block_locks_set <= `BLOCK_LOCK_RESET;
            dummy_clocks <= `DUMMY_SHORT;
            training_pattern_enable <= 1'b0;
            training_pattern <= 8'h00;
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_s;

            // serial front end
            if (cs_s) begin
                bit_cnt <= 5'h00;
                so_oe <= 1'b0;
            end else if (sclk_rise) begin
                shreg <= shift_in;
                if (bit_cnt != 5'h1f) begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
                if (bit_cnt == `BITS_CMD - 5'h01) begin
                    cmd <= shift_in;
                    out_byte <= read_value;
                end
                if (bit_cnt == `BITS_ONE_BYTE - 5'h01) begin
                    data0 <= shift_in;
                end
                if (bit_cnt == `BITS_TWO_BYTES - 5'h01) begin
                    data1 <= shift_in;
                end
            end else if (sclk_fall && bit_cnt >= `BITS_CMD && is_read) begin
                // other lines are ignored; the byte repeats while clocked
                so <= out_byte[7];
                out_byte <= {out_byte[6:0], out_byte[7]};
                so_oe <= 1'b1;
            end

            // self-timed write cycle
            case (state)
                ST_READY: begin
                    if (cs_rise) begin
                        if (cmd == `CMD_WRITE_ENABLE &&
                            bit_cnt == `BITS_CMD) begin
                            write_enable_latch <= 1'b1;
                        end else if (cmd == `CMD_WRITE_DISABLE &&
                            bit_cnt == `BITS_CMD) begin
                            write_enable_latch <= 1'b0;
                        end else if (cmd == `CMD_WRITE_STATUS_LOW &&
                            write_ok) begin
                            if (bit_cnt == `BITS_ONE_BYTE) begin
                                pend_status <= low_only;
                                pend_cfg <= config_now;
                                state <= ST_BUSY;
                                write_busy_flag <= 1'b1;
                                cycle_cnt <= 32'h0;
                            end else if (bit_cnt == `BITS_TWO_BYTES) begin
                                pend_status <= both_merge;
                                pend_cfg <= config_now;
                                state <= ST_BUSY;
                                write_busy_flag <= 1'b1;
                                cycle_cnt <= 32'h0;
                            end
                        end else if (cmd == `CMD_WRITE_STATUS_HIGH &&
                            write_ok && bit_cnt == `BITS_ONE_BYTE) begin
                            pend_status <= high_from0;
                            pend_cfg <= config_now;
                            state <= ST_BUSY;
                            write_busy_flag <= 1'b1;
                            cycle_cnt <= 32'h0;
                        end else if (cmd == `CMD_WRITE_CONFIG &&
                            write_ok && bit_cnt == `BITS_ONE_BYTE) begin
                            pend_status <= status_bits;
                            pend_cfg <= data0;
                            state <= ST_BUSY;
                            write_busy_flag <= 1'b1;
                            cycle_cnt <= 32'h0;
                        end
                    end
                end
                ST_BUSY: begin
                    // commands other than reads are dropped while busy
                    if (cycle_cnt >= WRITE_LAST) begin
                        state <= ST_READY;
                        write_busy_flag <= 1'b0;
                        write_enable_latch <= 1'b0;
                        status_bits <= pend_status;
                        hold_reset_select <= pend_cfg[`CFG_HOLD_RESET];
                        drive_strength <=
                            pend_cfg[`CFG_DRIVE_HI:`CFG_DRIVE_LO];
                        page_size <= next_page;
                        page_wrap_mask <= next_wrap;
                        erase_page_span <= next_span;
                        protection_scheme_select <=
                            pend_cfg[`CFG_PROT_SCHEME];
                        if (pend_cfg[`CFG_DUMMY_SEL]) begin
                            dummy_clocks <= `DUMMY_LONG;
                        end else begin
                            dummy_clocks <= `DUMMY_SHORT;
                        end
                        training_pattern_enable <=
                            pend_cfg[`CFG_TRAINING];
                        if (pend_cfg[`CFG_TRAINING]) begin
                            training_pattern <= `TRAINING_PATTERN;
                        end else begin
                            training_pattern <= 8'h00;
                        end
                    end else begin
                        cycle_cnt <= cycle_cnt + 32'h1;
                    end
                end
                default: begin
                    state <= ST_READY;
                    write_busy_flag <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: tb/flash_regs_assertions.sv
`default_nettype none
module flash_regs_assertions #(
    parameter int WRITE_CYCLES = 2000
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic so_oe,
    input wire logic write_busy_flag,
    input wire logic write_enable_latch,
    input wire logic hold_reset_select,
    input wire logic [1:0] drive_strength,
    input wire logic [1:0] page_size,
    input wire logic [9:0] page_wrap_mask,
    input wire logic [2:0] erase_page_span,
    input wire logic protection_scheme_select,
    input wire logic block_locks_set,
    input wire logic [3:0] dummy_clocks,
    input wire logic training_pattern_enable,
    input wire logic [7:0] training_pattern
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned busy_len;
    wire logic [7:0] cfg = {hold_reset_select, drive_strength, page_size,
        protection_scheme_select, dummy_clocks[3], training_pattern_enable};
    // counts sampled busy cycles so the full length can be checked
    always_ff @(posedge sys_clk) begin
        if (!reset_n)
            busy_len <= 0;
        else
            busy_len <= write_busy_flag ? busy_len + 1 : 0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_busy_full_length: assert property ($fell(write_busy_flag) |->
        busy_len == WRITE_CYCLES) else $error("busy length wrong");
    a_latch_with_busy: assert property ($fell(write_busy_flag) |->
        $fell(write_enable_latch)) else $error("latch not cleared at end");
    a_busy_needs_latch: assert property ($rose(write_busy_flag) |->
        write_enable_latch) else $error("write started without latch");
    a_start_after_deselect: assert property ($rose(write_busy_flag) |->
        cs_n && $past(cs_n, 3)) else $error("write started while selected");
    a_cfg_at_cycle_end: assert property ($changed(cfg) |->
        $fell(write_busy_flag)) else $error("config changed early");
    a_wrap_from_page: assert property (page_wrap_mask ==
        (page_size == 2'b01 ? 10'h1ff : page_size == 2'b10 ? 10'h3ff
        : 10'h0ff)) else $error("wrap point wrong");
    a_span_from_page: assert property (erase_page_span ==
        (page_size == 2'b01 ? 3'h2 : page_size == 2'b10 ? 3'h4 : 3'h1))
        else $error("erase span wrong");
    a_pattern_on_enable: assert property (training_pattern ==
        (training_pattern_enable ? 8'h34 : 8'h00))
        else $error("training pattern wrong");
    a_locks_stay_set: assert property (block_locks_set)
        else $error("block locks not set");
    a_dummy_legal: assert property (dummy_clocks == 4'h4 ||
        dummy_clocks == 4'h8) else $error("dummy count illegal");
    a_quiet_deselected: assert property (cs_n [*8] |-> !so_oe)
        else $error("output driven while deselected");
    c_write_done: cover property ($fell(write_busy_flag));
    c_read_out: cover property ($rose(so_oe));
    c_quad_page: cover property (page_size == 2'b10);
endmodule
bind flash_config_status_regs flash_regs_assertions #(
    .WRITE_CYCLES(WRITE_CYCLES)
) i_chk (.sys_clk, .reset_n, .cs_n, .so_oe, .write_busy_flag,
    .write_enable_latch, .hold_reset_select, .drive_strength, .page_size,
    .page_wrap_mask, .erase_page_span, .protection_scheme_select,
    .block_locks_set, .dummy_clocks, .training_pattern_enable,
    .training_pattern);
`default_nettype wire

// File: tb/flash_host_model.sv
`default_nettype none
// serial host, mode 0; sclk rests low between frames
module flash_host_model (
    output var logic cs_n,
    output var logic sclk,
    output var logic si,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // n bits of w from the top; bits past the command are read back
    task automatic frame(input logic [23:0] w, input int n,
        output logic [7:0] rd);
        int i;
        rd = 8'h00;
        cs_n = 1'b0;
        #24;
        for (i = 0; i < n; i++) begin
            si = w[23 - i];
            #24;
            sclk = 1'b1;
            #23;
            if (i >= 8)
                rd = {rd[6:0], so};
            #1;
            sclk = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        si = ~si;
        // deselect gap well above the synchroniser's need
        #150;
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WC = 1000;
    logic sys_clk = 1'b0, reset_n = 1'b0, wp_n = 1'b1;
    wire logic cs_n, sclk, si, so, so_oe, write_busy_flag, write_enable_latch;
    wire logic hold_reset_select, protection_scheme_select, block_locks_set;
    wire logic training_pattern_enable;
    wire logic [1:0] drive_strength, page_size;
    wire logic [9:0] page_wrap_mask;
    wire logic [2:0] erase_page_span;
    wire logic [3:0] dummy_clocks;
    wire logic [7:0] training_pattern;
    // an undriven line shows the inverse, so a missing enable is caught
    wire logic so_line = so_oe ? so : ~so;
    int n_mismatch = 0, total_checks = 0;
    logic [7:0] rd, prev;
    logic [7:0] vals [4] = '{8'h8f, 8'h35, 8'h5a, 8'h60};
    flash_config_status_regs #(.WRITE_CYCLES(WC)) i_dut (.sys_clk, .reset_n,
        .cs_n, .sclk, .si, .wp_n, .so, .so_oe, .write_busy_flag,
        .write_enable_latch, .hold_reset_select, .drive_strength, .page_size,
        .page_wrap_mask, .erase_page_span, .protection_scheme_select,
        .block_locks_set, .dummy_clocks, .training_pattern_enable,
        .training_pattern);
    flash_host_model i_host (.cs_n, .sclk, .si, .so(so_line));
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic xf(input logic [23:0] w, input int n);
        i_host.frame(w, n, rd);
    endtask
    task automatic rd_reg(input logic [7:0] c);
        xf({c, 16'h0000}, 16);
    endtask
    // poll busy by status reads, bounded
    task automatic wait_idle;
        int k;
        for (k = 0; k < 20; k++) begin
            rd_reg(8'h05);
            if (rd[0] === 1'b0)
                return;
        end
        n_mismatch++;
        conclude();
    endtask
    task automatic exp_cfg(input logic [7:0] v);
        chk(hold_reset_select, v[7]);
        chk(drive_strength, v[6:5]);
        chk(page_size, v[4:3]);
        chk(page_wrap_mask, v[4:3] == 2'b01 ? 10'h1ff :
            v[4:3] == 2'b10 ? 10'h3ff : 10'h0ff);
        chk(erase_page_span, v[4:3] == 2'b01 ? 3'h2 :
            v[4:3] == 2'b10 ? 3'h4 : 3'h1);
        chk(protection_scheme_select, v[2]);
        chk(block_locks_set, 1'b1);
        chk(dummy_clocks, v[1] ? 4'h8 : 4'h4);
        chk(training_pattern_enable, v[0]);
        chk(training_pattern, v[0] ? 8'h34 : 8'h00);
        rd_reg(8'h15);
        chk(rd, v);
    endtask
    initial begin
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        exp_cfg(8'h00);
        chk({write_busy_flag, write_enable_latch}, 2'b00);
        xf(24'h060000, 8);
        xf(24'h040000, 8);
        chk(write_enable_latch, 1'b0);
        xf({8'h11, 8'h8f, 8'h00}, 16);
        chk(write_busy_flag, 1'b0);
        prev = 8'h00;
        foreach (vals[i]) begin
            xf(24'h060000, 8);
            chk(write_enable_latch, 1'b1);
            xf({8'h11, vals[i], 8'h00}, 16);
            chk(write_busy_flag, 1'b1);
            rd_reg(8'h15);
            chk(rd, prev);
            rd_reg(8'h05);
            chk(rd[1:0], 2'b11);
            wait_idle();
            chk(write_enable_latch, 1'b0);
            exp_cfg(vals[i]);
            prev = vals[i];
        end
        xf(24'h060000, 8);
        xf({8'h11, 8'h01, 8'h00}, 24);
        xf({8'h11, 8'h01, 8'h00}, 15);
        chk(write_busy_flag, 1'b0);
        xf({8'h01, 16'h7e7c}, 24);
        wait_idle();
        rd_reg(8'h05);
        chk(rd, 8'h7c);
        rd_reg(8'h35);
        chk(rd, 8'h78);
        xf(24'h060000, 8);
        xf({8'h31, 8'h44, 8'h00}, 16);
        wait_idle();
        rd_reg(8'h35);
        chk(rd, 8'h40);
        xf(24'h060000, 8);
        xf({8'h01, 8'hfd, 8'h00}, 16);
        wait_idle();
        rd_reg(8'h05);
        chk(rd, 8'hfc);
        rd_reg(8'h35);
        chk(rd, 8'h00);
        xf(24'h060000, 8);
        xf({8'h01, 8'h00, 8'h00}, 12);
        chk(write_busy_flag, 1'b0);
        @(negedge sys_clk);
        wp_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        xf({8'h11, 8'h01, 8'h00}, 16);
        chk(write_busy_flag, 1'b0);
        xf({8'h01, 8'h00, 8'h00}, 16);
        chk(write_busy_flag, 1'b0);
        @(negedge sys_clk);
        wp_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        xf({8'h11, 8'h01, 8'h00}, 16);
        wait_idle();
        rd_reg(8'h15);
        chk(rd, 8'h01);
        conclude();
    end
endmodule
`default_nettype wire
